// *** src/bstp_test_port.sv ***
/*
 Boundary-scan test access port: controller, opcode, bypass, identity and
 pin cell chain. Assumes functional pins and core signals on ref_clk and
 the tester driving the serial pins on the test clock.
*/
//
// Contract
// - Opcode 0000 drives cell contents onto functional outputs and selects the cell chain.
// - Opcode 1111 routes serial data through the one-stage bypass.
// - Opcode 0010 captures the fixed 32-bit identity and selects it as the path.
// - Opcode 0100 floats every functional output and selects the bypass.
// - Opcode 0011 holds outputs at cell values while selecting the bypass.
// - Opcode 0001 selects the cell chain and captures pin states for shifting out.
// - Under sample/preload new cell values shift in without touching normal operation.
// - Identity bits 31:28 hold the revision field.
// - Identity bits 27:12 hold the 16-bit part number.
// - Identity bits 11:1 hold the 11-bit manufacturer code.
// - Identity bit 0 always reads one.
// - The cell chain covers all functional inputs but not the four serial test inputs.
// - Forcing and capture act on all outputs except the serial output.
`timescale 1ns/1ps
`include "bstp_params.svh"

module bstp_test_port
	import bstp_pkg::*;
(
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	input  wire logic                    testClk,
	input  wire logic                    testRst_n,
	input  wire bstp_ser_t               serIn,
	output logic                         serOut,
	output logic                         serOutEn,
	input  wire logic [`BSTP_IN_W-1:0]   pinIn,
	input  wire logic [`BSTP_OUT_W-1:0]  coreOut,
	input  wire logic [`BSTP_OUT_W-1:0]  coreOutEn,
	output logic [`BSTP_OUT_W-1:0]       pinOut,
	output logic [`BSTP_OUT_W-1:0]       pinOutEn,
	output logic [`BSTP_OP_W-1:0]        activeOpcode
);

	// ************************************************************
	// Decode
	// ************************************************************
	function automatic bstp_dec_t decodeOp(input logic [`BSTP_OP_W-1:0] op);
		bstp_dec_t d;
		d = '0;
		unique case (op)
			`BSTP_OP_EXTEST: begin
				d.selChain = 1'b1;
				d.forceOut = 1'b1;
			end
			`BSTP_OP_SAMPLE: d.selChain = 1'b1;
			`BSTP_OP_IDCODE: d.selId = 1'b1;
			`BSTP_OP_CLAMP: d.forceOut = 1'b1;
			`BSTP_OP_HIGHZ: d.floatOut = 1'b1;
			default: d = '0; // Bypass and reserved codes use bypass
		endcase
		return d;
	endfunction

	// ************************************************************
	// Test clock domain: reset synchroniser and pin synchroniser
	// ************************************************************
	logic        tRstMeta_ff;
	logic        tRst_ff;
	logic [1:0]  serMeta_ff;
	logic [1:0]  serSync_ff;
	bstp_ser_t   ser;

	// Async test reset, released on the test clock
	always_ff @(posedge testClk or negedge testRst_n) begin
		if (!testRst_n) begin
			tRstMeta_ff <= 1'b0;
			tRst_ff     <= 1'b0;
		end else begin
			tRstMeta_ff <= 1'b1;
			tRst_ff     <= tRstMeta_ff;
		end
	end

	// Serial pins come straight off the tester, so two stages first
	always_ff @(posedge testClk) begin
		serMeta_ff <= serIn;
		serSync_ff <= serMeta_ff;
	end
	assign ser = bstp_ser_t'(serSync_ff);

	// ************************************************************
	// Controller
	// ************************************************************
	bstp_tap_t tap_ff;
	bstp_tap_t nxt_tap;

	// Standard sixteen-state walk; five TMS highs reach reset from anywhere
	always_comb begin
		unique case (tap_ff)
			TlReset: nxt_tap = ser.tms ? TlReset : RunIdle;
			RunIdle: nxt_tap = ser.tms ? SelDr : RunIdle;
			SelDr:   nxt_tap = ser.tms ? SelIr : CapDr;
			CapDr:   nxt_tap = ser.tms ? Ex1Dr : ShDr;
			ShDr:    nxt_tap = ser.tms ? Ex1Dr : ShDr;
			Ex1Dr:   nxt_tap = ser.tms ? UpdDr : PauseDr;
			PauseDr: nxt_tap = ser.tms ? Ex2Dr : PauseDr;
			Ex2Dr:   nxt_tap = ser.tms ? UpdDr : ShDr;
			UpdDr:   nxt_tap = ser.tms ? SelDr : RunIdle;
			SelIr:   nxt_tap = ser.tms ? TlReset : CapIr;
			CapIr:   nxt_tap = ser.tms ? Ex1Ir : ShIr;
			ShIr:    nxt_tap = ser.tms ? Ex1Ir : ShIr;
			Ex1Ir:   nxt_tap = ser.tms ? UpdIr : PauseIr;
			PauseIr: nxt_tap = ser.tms ? Ex2Ir : PauseIr;
			Ex2Ir:   nxt_tap = ser.tms ? UpdIr : ShIr;
			UpdIr:   nxt_tap = ser.tms ? SelDr : RunIdle;
		endcase
	end

	// Test reset acts at once, even while the tester holds the clock still
	always_ff @(posedge testClk or negedge tRst_ff) begin
		if (!tRst_ff)
			tap_ff <= TlReset;
		else
			tap_ff <= nxt_tap;
	end

	// ************************************************************
	// Opcode register
	// ************************************************************
	logic [`BSTP_OP_W-1:0] opShift_ff;
	logic [`BSTP_OP_W-1:0] opcode_ff;
	bstp_dec_t             dec;

	// Shift lsb first, the tdi bit entering at the top
	always_ff @(posedge testClk or negedge tRst_ff) begin
		if (!tRst_ff)
			opShift_ff <= `BSTP_OP_RESET;
		else if (tap_ff == CapIr)
			opShift_ff <= {{(`BSTP_OP_W-2){1'b0}}, `BSTP_CAP_LOW};
		else if (tap_ff == ShIr)
			opShift_ff <= {ser.tdi, opShift_ff[`BSTP_OP_W-1:1]};
	end

	// Reset leaves the identity path selected, as is usual for such ports
	always_ff @(posedge testClk or negedge tRst_ff) begin
		if (!tRst_ff)
			opcode_ff <= `BSTP_OP_RESET;
		else if (tap_ff == TlReset)
			opcode_ff <= `BSTP_OP_RESET;
		else if (tap_ff == UpdIr)
			opcode_ff <= opShift_ff;
	end
	assign dec = decodeOp(opcode_ff);

	// ************************************************************
	// Data registers
	// ************************************************************
	logic                    pass_ff;
	logic [`BSTP_ID_W-1:0]   idShift_ff;
	logic [`BSTP_CHAIN_W-1:0] chain_ff;
	logic [`BSTP_OUT_W-1:0]  holdOut_ff;
	logic [`BSTP_OUT_W-1:0]  holdEn_ff;
	logic [`BSTP_ID_W-1:0]   idValue;
	logic [`BSTP_CHAIN_W-1:0] pinSnap;

	// Fixed identity word
	assign idValue[`BSTP_REV_MSB:`BSTP_REV_LSB]   = `BSTP_REV_VAL;
	assign idValue[`BSTP_PART_MSB:`BSTP_PART_LSB] = `BSTP_PART_VAL;
	assign idValue[`BSTP_MFR_MSB:`BSTP_MFR_LSB]   = `BSTP_MFR_VAL;
	assign idValue[0]                             = 1'b1;

	// Cells: functional inputs and core outputs only, no serial test pins
	assign pinSnap = {pinIn, coreOut};

	// Pins and core values come from outside the test clock: two stages
	logic [`BSTP_CHAIN_W-1:0] snapMeta_ff;
	logic [`BSTP_CHAIN_W-1:0] snapSync_ff;

	always_ff @(posedge testClk) begin
		snapMeta_ff <= pinSnap;
		snapSync_ff <= snapMeta_ff;
	end

	// One-stage bypass, loaded with zero at capture
	always_ff @(posedge testClk) begin
		if (tap_ff == CapDr)
			pass_ff <= 1'b0;
		else if (tap_ff == ShDr)
			pass_ff <= ser.tdi;
	end

	// Identity capture and shift
	always_ff @(posedge testClk) begin
		if (tap_ff == CapDr && dec.selId)
			idShift_ff <= idValue;
		else if (tap_ff == ShDr && dec.selId)
			idShift_ff <= {ser.tdi, idShift_ff[`BSTP_ID_W-1:1]};
	end

	// Pin cell chain; capture takes the synchronised snapshot, so a value
	// that moves within two test clocks of capture may read old or new
	always_ff @(posedge testClk) begin
		if (tap_ff == CapDr && dec.selChain)
			chain_ff <= snapSync_ff;
		else if (tap_ff == ShDr && dec.selChain)
			chain_ff <= {ser.tdi, chain_ff[`BSTP_CHAIN_W-1:1]};
	end

	// Update stage: preload lands here, core keeps running untouched
	always_ff @(posedge testClk or negedge tRst_ff) begin
		if (!tRst_ff) begin
			holdOut_ff <= '0;
			holdEn_ff  <= '0;
		end else if (tap_ff == UpdDr && dec.selChain) begin
			holdOut_ff <= chain_ff[`BSTP_OUT_W-1:0];
			holdEn_ff  <= '1;
		end
	end

	// ************************************************************
	// Serial output, changes on the falling test clock
	// ************************************************************
	logic tdoBit;
	logic tdo_ff;
	logic tdoEn_ff;

	always_comb begin
		if (tap_ff == ShIr)
			tdoBit = opShift_ff[0];
		else if (dec.selChain)
			tdoBit = chain_ff[0];
		else if (dec.selId)
			tdoBit = idShift_ff[0];
		else
			tdoBit = pass_ff;
	end

	always_ff @(negedge testClk or negedge tRst_ff) begin
		if (!tRst_ff) begin
			tdo_ff   <= 1'b0;
			tdoEn_ff <= 1'b0;
		end else begin
			tdo_ff   <= tdoBit;
			tdoEn_ff <= (tap_ff == ShIr) || (tap_ff == ShDr);
		end
	end
	assign serOut   = tdo_ff;
	assign serOutEn = tdoEn_ff;

	// ************************************************************
	// Crossing to ref_clk: words change at most once per test clock
	// ************************************************************
	logic [`BSTP_OP_W-1:0]  opMeta_ff;
	logic [`BSTP_OP_W-1:0]  opSync_ff;
	logic [`BSTP_OP_W-1:0]  opSeen_ff;
	logic [`BSTP_OP_W-1:0]  opAct_ff;
	logic [`BSTP_OUT_W-1:0] hoMeta_ff;
	logic [`BSTP_OUT_W-1:0] hoSync_ff;
	logic [`BSTP_OUT_W-1:0] hoSeen_ff;
	logic [`BSTP_OUT_W-1:0] hoAct_ff;
	logic [`BSTP_OUT_W-1:0] pinOut_ff;
	logic [`BSTP_OUT_W-1:0] pinOutEn_ff;
	bstp_dec_t              refDec;

	// Two stages per bit, then one more sample for the agreement test
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			opMeta_ff <= `BSTP_OP_RESET;
			opSync_ff <= `BSTP_OP_RESET;
			opSeen_ff <= `BSTP_OP_RESET;
			hoMeta_ff <= '0;
			hoSync_ff <= '0;
			hoSeen_ff <= '0;
		end else begin
			opMeta_ff <= opcode_ff;
			opSync_ff <= opMeta_ff;
			opSeen_ff <= opSync_ff;
			hoMeta_ff <= holdOut_ff;
			hoSync_ff <= hoMeta_ff;
			hoSeen_ff <= hoSync_ff;
		end
	end

	// Per-bit stages may show a one-cycle mix of old and new bits; taking a
	// word only when two samples agree keeps a stray code off the pins
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			opAct_ff <= `BSTP_OP_RESET;
			hoAct_ff <= '0;
		end else if (opSync_ff == opSeen_ff && hoSync_ff == hoSeen_ff) begin
			opAct_ff <= opSync_ff;
			hoAct_ff <= hoSync_ff;
		end
	end
	assign refDec       = decodeOp(opAct_ff);
	assign activeOpcode = opAct_ff;

	// Functional output drivers, serial output is never touched here
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pinOut_ff   <= '0;
			pinOutEn_ff <= '0;
		end else if (refDec.floatOut) begin
			pinOut_ff   <= '0;
			pinOutEn_ff <= '0;
		end else if (refDec.forceOut) begin
			pinOut_ff   <= hoAct_ff;
			pinOutEn_ff <= '1;
		end else begin
			pinOut_ff   <= coreOut;
			pinOutEn_ff <= coreOutEn;
		end
	end
	assign pinOut   = pinOut_ff;
	assign pinOutEn = pinOutEn_ff;

	// ************************************************************
	// Checks
	// ************************************************************
	tap_reset_a: assert property (@(posedge testClk) disable iff (!tRst_ff)
		ser.tms [*5] |=> tap_ff == TlReset)
		else $error("five tms highs did not reset controller");
	id_capture_a: assert property (@(posedge testClk) disable iff (!tRst_ff)
		(tap_ff == CapDr && dec.selId) |=> idShift_ff == idValue)
		else $error("identity not captured");
	id_lsb_a: assert property (@(posedge testClk) disable iff (!tRst_ff)
		(tap_ff == ShDr && dec.selId && $past(tap_ff) == CapDr) |-> serOut == 1'b1)
		else $error("identity marker bit not first out");
	reset_opcode_a: assert property (@(posedge testClk) disable iff (!tRst_ff)
		(tap_ff == TlReset) |=> opcode_ff == `BSTP_OP_RESET)
		else $error("controller reset left opcode loaded");
	op_shift_a: assert property (@(posedge testClk) disable iff (!tRst_ff)
		(tap_ff == ShIr) |=> opShift_ff[3] == $past(ser.tdi))
		else $error("opcode shift wrong");
	bypass_path_a: assert property (@(posedge testClk) disable iff (!tRst_ff)
		(tap_ff == ShDr && opcode_ff == 4'hf) |=> pass_ff == $past(ser.tdi))
		else $error("bypass stage did not follow input");
	highz_float_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		refDec.floatOut |=> pinOutEn == '0)
		else $error("outputs not floated");
	clamp_force_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		refDec.forceOut |=> pinOut == $past(hoAct_ff) && pinOutEn == '1)
		else $error("outputs not forced");
	chain_capture_a: assert property (@(posedge testClk) disable iff (!tRst_ff)
		(tap_ff == CapDr && dec.selChain) |=> chain_ff == $past(snapSync_ff))
		else $error("pin cells not captured");
	normal_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(opAct_ff == 4'h1) |=> pinOut == $past(coreOut))
		else $error("sample disturbed outputs");
	op_update_c: cover property (@(posedge testClk) tap_ff == UpdIr);
	id_shift_c: cover property (@(posedge testClk) tap_ff == ShDr && dec.selId);
	extest_c: cover property (@(posedge ref_clk) opAct_ff == 4'h0);
	sample_c: cover property (@(posedge ref_clk) opAct_ff == 4'h1);
	highz_c: cover property (@(posedge ref_clk) refDec.floatOut);

endmodule

// *** src/bstp_params.svh ***
/*
 Widths, field positions, instruction codes and reset values for the
 boundary-scan test port. Assumes inclusion by bare name from the package.
*/
`ifndef BSTP_PARAMS_SVH
`define BSTP_PARAMS_SVH

// ************************************************************
// Instruction codes
// ************************************************************
`define BSTP_OP_EXTEST   4'h0
`define BSTP_OP_SAMPLE   4'h1
`define BSTP_OP_IDCODE   4'h2
`define BSTP_OP_CLAMP    4'h3
`define BSTP_OP_HIGHZ    4'h4
`define BSTP_OP_BYPASS   4'hf
`define BSTP_OP_RESET    4'h2

// ************************************************************
// Widths and identity fields (identity values are arbitrary)
// ************************************************************
`define BSTP_OP_W        4
`define BSTP_ID_W        32
`define BSTP_IN_W        8
`define BSTP_OUT_W       8
`define BSTP_CHAIN_W     16
`define BSTP_REV_MSB     31
`define BSTP_REV_LSB     28
`define BSTP_PART_MSB    27
`define BSTP_PART_LSB    12
`define BSTP_MFR_MSB     11
`define BSTP_MFR_LSB     1
`define BSTP_REV_VAL     4'h5
`define BSTP_PART_VAL    16'h1a2b
`define BSTP_MFR_VAL     11'h2c5
`define BSTP_CAP_LOW     2'h1

`endif

// *** src/bstp_pkg.sv ***
/*
 Types shared by the boundary-scan test port.
 Assumes bstp_params.svh is on the include path.
*/
package bstp_pkg;
`include "bstp_params.svh"

	// Test controller states
	typedef enum logic [3:0] {
		TlReset, RunIdle, SelDr, CapDr, ShDr, Ex1Dr, PauseDr, Ex2Dr, UpdDr,
		SelIr, CapIr, ShIr, Ex1Ir, PauseIr, Ex2Ir, UpdIr
	} bstp_tap_t;

	// Serial pins from the tester
	typedef struct packed {
		logic tms;
		logic tdi;
	} bstp_ser_t;

	// Decoded instruction effects
	typedef struct packed {
		logic selChain;
		logic selId;
		logic forceOut;
		logic floatOut;
	} bstp_dec_t;
endpackage

// *** tb/bstp_tester_model.sv ***
/*
 Tester model for the serial test side: makes the test clock only inside
 frames and samples the serial output just before each rising edge.
 Assumes the bench composes tms/tdi bit strings from the idle state.
*/
`timescale 1ns/1ps

module bstp_tester_model
	import bstp_pkg::*;
(
	output logic      testClk,
	output logic      testRst_n,
	output bstp_ser_t serIn,
	input  wire logic serOut,
	input  wire logic serOutEn
);
	// ************************************************************
	// Idle levels
	// ************************************************************
	initial begin
		testClk = 1'b1;
		testRst_n = 1'b1; // High so the first pulse is a real falling edge
		serIn = '{tms: 1'b1, tdi: 1'b0};
	end

	// One bit per cycle; only shift-state cycles are collected
	task automatic frame(input logic [63:0] tms, input logic [63:0] tdi, input int len,
		output logic [63:0] got, output int ng);
		got = '0;
		ng = 0;
		for (int i = 0; i < len; i++) begin
			#1 serIn = '{tms: tms[i], tdi: tdi[i]};
			#79 testClk = 1'b0;
			#79;
			if (serOutEn === 1'b1) begin
				got[ng] = serOut;
				ng++;
			end
			#1 testClk = 1'b1;
		end
		// Clock stops; data line must not keep its last value
		#1 serIn.tdi = ~serIn.tdi;
	endtask

	// Test reset pulse, longer than the minimum width
	task automatic pulse_reset();
		#1 testRst_n = 1'b0;
		#100 testRst_n = 1'b1;
	endtask
endmodule

// *** tb/boundary_scan_test_port_tb.sv ***
/*
 Bench for the test port: tester model on the serial side, random core pins.
 Assumes bstp_pkg and the tester model are compiled first.
*/
`timescale 1ns/1ps
`include "bstp_params.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end

module boundary_scan_test_port_tb
	import bstp_pkg::*;
;
	logic                   ref_clk;
	logic                   rst_n;
	logic                   testClk;
	logic                   testRst_n;
	bstp_ser_t              serIn;
	logic                   serOut;
	logic                   serOutEn;
	logic [`BSTP_IN_W-1:0]  pinIn;
	logic [`BSTP_OUT_W-1:0] coreOut;
	logic [`BSTP_OUT_W-1:0] coreOutEn;
	logic [`BSTP_OUT_W-1:0] pinOut;
	logic [`BSTP_OUT_W-1:0] pinOutEn;
	logic [`BSTP_OP_W-1:0]  activeOpcode;
	logic [63:0]            got;
	logic [63:0]            q;
	int                     k;
	int                     miscompares = 0;
	int                     checked = 0;

	bstp_test_port bstp_test_port_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.testClk(testClk), .testRst_n(testRst_n), .serIn(serIn), .serOut(serOut),
		.serOutEn(serOutEn), .pinIn(pinIn), .coreOut(coreOut), .coreOutEn(coreOutEn),
		.pinOut(pinOut), .pinOutEn(pinOutEn), .activeOpcode(activeOpcode));

	bstp_tester_model tester_inst (.testClk(testClk), .testRst_n(testRst_n),
		.serIn(serIn), .serOut(serOut), .serOutEn(serOutEn));

	// Core clock, 40 ns
	always #20 ref_clk = ~ref_clk;

	// ************************************************************
	// Tasks
	// ************************************************************
	// Scan from idle; padding flushes the two-stage input lag
	task automatic scan(input bit isOp, input logic [63:0] data, input int n);
		logic [63:0] t;
		logic [63:0] d;
		int          p;
		int          ng;
		t = '0;
		d = '0;
		p = isOp ? 5 : 4;
		t[1] = 1'b1;
		t[2] = isOp;
		for (int i = 0; i < n; i++)
			d[p+i] = data[i];
		t[p+n-1] = 1'b1;
		t[p+n] = 1'b1;
		tester_inst.frame(t, d, p + n + 5, got, ng);
		`CHK("shift count", n, ng)
		repeat (12) @(posedge ref_clk);
		#1;
	endtask

	task automatic load(input logic [3:0] op);
		scan(1'b1, {60'h0, op}, 4);
		`CHK("opcode capture", 4'h1, got[3:0])
		`CHK("opcode", op, activeOpcode)
	endtask

	// Bypass path shows a zero first, then the data one cycle late
	task automatic byp();
		q = {48'h0, 16'($urandom)};
		scan(1'b0, q, 16);
		`CHK("bypass path", {q[14:0], 1'b0}, got[15:0])
	endtask

	task automatic new_core();
		@(posedge ref_clk);
		#1;
		pinIn = 8'($urandom);
		coreOut = 8'($urandom);
		coreOutEn = 8'($urandom);
	endtask

	task automatic close_out();
		$display("counts: checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		pinIn = '0;
		coreOut = '0;
		coreOutEn = '0;
		void'($urandom(32'h093e));
		repeat (8) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		tester_inst.pulse_reset();
		repeat (4) @(posedge ref_clk);
		#1;
		`CHK("reset opcode", `BSTP_OP_RESET, activeOpcode)
		load(`BSTP_OP_IDCODE);
		scan(1'b0, 64'h0, 32);
		`CHK("revision", `BSTP_REV_VAL, got[31:28])
		`CHK("part number", `BSTP_PART_VAL, got[27:12])
		`CHK("maker code", `BSTP_MFR_VAL, got[11:1])
		`CHK("id marker", 1'b1, got[0])
		$display("test identity done");
		new_core();
		load(`BSTP_OP_BYPASS);
		byp();
		`CHK("normal pins", coreOut, pinOut)
		`CHK("normal enables", coreOutEn, pinOutEn)
		$display("test bypass done");
		load(`BSTP_OP_SAMPLE);
		q = {48'h0, 16'($urandom)};
		scan(1'b0, q, 16);
		`CHK("sampled pins", {pinIn, coreOut}, got[15:0])
		`CHK("pins during preload", coreOut, pinOut)
		$display("test sample done");
		load(`BSTP_OP_EXTEST);
		`CHK("forced pins", q[7:0], pinOut)
		`CHK("forced enables", 8'hff, pinOutEn)
		q = {48'h0, 16'($urandom)};
		scan(1'b0, q, 16);
		`CHK("updated pins", q[7:0], pinOut)
		$display("test extest done");
		k = q[7:0];
		load(`BSTP_OP_CLAMP);
		byp();
		`CHK("clamped pins", 8'(k), pinOut)
		`CHK("clamped enables", 8'hff, pinOutEn)
		load(`BSTP_OP_HIGHZ);
		byp();
		`CHK("floated enables", 8'h00, pinOutEn)
		$display("test clamp and float done");
		load(`BSTP_OP_BYPASS);
		tester_inst.frame(64'h1f, 64'h0, 10, got, k);
		repeat (12) @(posedge ref_clk);
		#1;
		`CHK("mode select reset", `BSTP_OP_RESET, activeOpcode)
		load(`BSTP_OP_BYPASS);
		tester_inst.pulse_reset();
		repeat (12) @(posedge ref_clk);
		#1;
		`CHK("test reset", `BSTP_OP_RESET, activeOpcode)
		$display("test controller reset done");
		close_out();
	end

	// Whole sequence needs roughly 55 us; this cuts a hang short
	initial begin
		#1_000_000;
		miscompares++;
		close_out();
	end
endmodule
